//--- include/bcpm_pkg.sv
// Constants for the bridge clock power and capability register bank.
// Assumes a plain register port with 8-bit byte addresses, 32-bit data.
package bcpm_pkg;
	localparam logic [7:0] OFS_CLK_PWR_CTRL = 8'h9C;
	localparam logic [7:0] OFS_LINK_PHY_TUNING = 8'hA4;
	localparam logic [7:0] OFS_CAP_HEADER = 8'hA8;
	localparam logic [7:0] OFS_VENDOR_ID = 8'hAC;

	localparam int POS_CLKRUN_EN = 0;
	localparam int POS_CLKRUN_MODE = 1;
	localparam int POS_CLK_STOPPED = 2;

	localparam int POS_L0S_CTRL = 16;
	localparam int POS_SCRAMBLE_LO = 17;
	localparam int POS_L1_TIMER_LO = 19;

	localparam int POS_NEXT_PTR_LO = 8;

	localparam logic RST_CLKRUN_MODE = 1'b0;
	localparam logic RST_L0S_CTRL = 1'b1;
	localparam logic [1:0] RST_SCRAMBLE = 2'h0;
	localparam logic [1:0] RST_L1_TIMER = 2'h1;

	localparam logic [7:0] CAP_ID_SUBSYS = 8'h0D;
	localparam logic [7:0] NEXT_PTR_DEFAULT = 8'hB0;
	localparam logic [7:0] NEXT_PTR_SLOT_ID = 8'hA0;
	localparam logic [7:0] NEXT_PTR_LEGACY = 8'hF0;
	localparam logic [15:0] CAP_HDR_RSVD = 16'h0000;
	localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;
endpackage : bcpm_pkg

//--- src/bcpm_regs.sv
// Clock power management and capability register bank of the bridge.
// Assumes a one-cycle register port, straps from pins, and same-clock
// status inputs from the bridge core.
`timescale 1ns/1ps
module bcpm_regs #(
	parameter logic [15:0] SUBSYS_VENDOR_ID = 16'h1A2B
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [31:0] RDATA_O,
	input wire logic [1:0] STRAP_REQ_N_I,
	input wire logic D3HOT_I,
	input wire logic SEC_BUS_IDLE_I,
	input wire logic PRI_REQ_PEND_I,
	input wire logic RX_ELEC_IDLE_I,
	input wire logic L0S_REQ_I,
	input wire logic SLOT_ID_CAP_EN_I,
	input wire logic LEGACY_MODE_I,
	output logic CLK_PM_EN_O,
	output logic CLKRUN_EN_O,
	output logic SEC_CLK_STOP_O,
	output logic L0S_ENTER_O,
	output logic [1:0] SCRAMBLE_CTRL_O,
	output logic [1:0] L1_TIMER_SEL_O
);
	// The subsystem vendor identifier default is arbitrary.

	////////////////////////////////////////////////////////////////////////
	// Strap synchroniser and capture at reset release.

	logic [1:0] strap_s1_q;
	logic [1:0] strap_s2_q;
	logic [1:0] strap_s3_q;
	logic captured_q;
	logic captured_d;
	logic cpm_en_q;
	logic cpm_en_d;
	logic strap_stable;
	logic capture_now;

	always_ff @(posedge CLK_I) begin
		strap_s1_q <= STRAP_REQ_N_I;
		strap_s2_q <= strap_s1_q;
		strap_s3_q <= strap_s2_q;
	end

	assign strap_stable = (strap_s2_q == strap_s3_q);
	assign capture_now = !captured_q && strap_stable;
	assign captured_d = captured_q | strap_stable;
	assign cpm_en_d = capture_now ? (strap_s3_q == 2'b00) : cpm_en_q;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			captured_q <= 1'b0;
			cpm_en_q <= 1'b0;
		end else begin
			captured_q <= captured_d;
			cpm_en_q <= cpm_en_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address decode.

	logic sel_clk;
	logic sel_phy;
	logic sel_hdr;
	logic sel_vid;
	logic wr_clk;
	logic wr_phy;
	logic wr_hdr;

	assign sel_clk = (ADDR_I == bcpm_pkg::OFS_CLK_PWR_CTRL);
	assign sel_phy = (ADDR_I == bcpm_pkg::OFS_LINK_PHY_TUNING);
	assign sel_hdr = (ADDR_I == bcpm_pkg::OFS_CAP_HEADER);
	assign sel_vid = (ADDR_I == bcpm_pkg::OFS_VENDOR_ID);
	assign wr_clk = WR_I && sel_clk;
	assign wr_phy = WR_I && sel_phy;
	assign wr_hdr = WR_I && sel_hdr;

	////////////////////////////////////////////////////////////////////////
	// Clock-run controls.

	logic clkrun_en_q;
	logic clkrun_en_d;
	logic clkrun_mode_q;
	logic clkrun_mode_d;

	always_comb begin
		clkrun_en_d = clkrun_en_q;
		clkrun_mode_d = clkrun_mode_q;
		if (capture_now) begin
			clkrun_en_d = (strap_s3_q == 2'b00);
		end else if (wr_clk && cpm_en_q) begin
			clkrun_en_d = WDATA_I[bcpm_pkg::POS_CLKRUN_EN];
			clkrun_mode_d = WDATA_I[bcpm_pkg::POS_CLKRUN_MODE];
		end
		if (!cpm_en_d) begin
			clkrun_en_d = 1'b0;
			clkrun_mode_d = bcpm_pkg::RST_CLKRUN_MODE;
		end
	end

	logic stop_d;
	logic stop_q;

	assign stop_d = clkrun_en_q && (clkrun_mode_q ?
		(SEC_BUS_IDLE_I && !PRI_REQ_PEND_I) : D3HOT_I);

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			clkrun_en_q <= 1'b0;
			clkrun_mode_q <= bcpm_pkg::RST_CLKRUN_MODE;
			stop_q <= 1'b0;
		end else begin
			clkrun_en_q <= clkrun_en_d;
			clkrun_mode_q <= clkrun_mode_d;
			stop_q <= stop_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link and PHY tuning controls.

	logic l0s_ctrl_q;
	logic [1:0] scramble_q;
	logic [1:0] l1_timer_q;
	logic l0s_enter_q;
	logic l0s_enter_d;

	assign l0s_enter_d = L0S_REQ_I && (!l0s_ctrl_q || RX_ELEC_IDLE_I);

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			l0s_ctrl_q <= bcpm_pkg::RST_L0S_CTRL;
			scramble_q <= bcpm_pkg::RST_SCRAMBLE;
			l1_timer_q <= bcpm_pkg::RST_L1_TIMER;
			l0s_enter_q <= 1'b0;
		end else begin
			if (wr_phy) begin
				l0s_ctrl_q <= WDATA_I[bcpm_pkg::POS_L0S_CTRL];
				scramble_q <= WDATA_I[bcpm_pkg::POS_SCRAMBLE_LO +: 2];
				l1_timer_q <= WDATA_I[bcpm_pkg::POS_L1_TIMER_LO +: 2];
			end
			l0s_enter_q <= l0s_enter_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Capability header next pointer.

	logic [7:0] next_ptr_q;
	logic [7:0] next_ptr_rd;
	logic ptr_wr_ok;

	assign ptr_wr_ok = wr_hdr && SLOT_ID_CAP_EN_I && !LEGACY_MODE_I &&
		(WDATA_I[bcpm_pkg::POS_NEXT_PTR_LO +: 8] ==
		bcpm_pkg::NEXT_PTR_SLOT_ID);
	assign next_ptr_rd = LEGACY_MODE_I ? bcpm_pkg::NEXT_PTR_LEGACY
		: next_ptr_q;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			next_ptr_q <= bcpm_pkg::NEXT_PTR_DEFAULT;
		end else if (ptr_wr_ok) begin
			next_ptr_q <= bcpm_pkg::NEXT_PTR_SLOT_ID;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux and registered read data.

	logic [31:0] rd_clk;
	logic [31:0] rd_phy;
	logic [31:0] rd_hdr;
	logic [31:0] rd_vid;
	logic [31:0] rd_mux;

	assign rd_clk = {29'h0000_0000, stop_q, clkrun_mode_q, clkrun_en_q};
	assign rd_phy = {11'h000, l1_timer_q, scramble_q, l0s_ctrl_q,
		16'h0000};
	assign rd_hdr = {bcpm_pkg::CAP_HDR_RSVD, next_ptr_rd,
		bcpm_pkg::CAP_ID_SUBSYS};
	assign rd_vid = {16'h0000, SUBSYS_VENDOR_ID};
	assign rd_mux = sel_clk ? rd_clk : sel_phy ? rd_phy : sel_hdr ? rd_hdr
		: sel_vid ? rd_vid : bcpm_pkg::RDATA_UNMAPPED;

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			RDATA_O <= bcpm_pkg::RDATA_UNMAPPED;
			CLK_PM_EN_O <= 1'b0;
			CLKRUN_EN_O <= 1'b0;
			SEC_CLK_STOP_O <= 1'b0;
			L0S_ENTER_O <= 1'b0;
			SCRAMBLE_CTRL_O <= bcpm_pkg::RST_SCRAMBLE;
			L1_TIMER_SEL_O <= bcpm_pkg::RST_L1_TIMER;
		end else begin
			RDATA_O <= RD_I ? rd_mux : bcpm_pkg::RDATA_UNMAPPED;
			CLK_PM_EN_O <= cpm_en_q;
			CLKRUN_EN_O <= clkrun_en_q;
			SEC_CLK_STOP_O <= stop_q;
			L0S_ENTER_O <= l0s_enter_q;
			SCRAMBLE_CTRL_O <= scramble_q;
			L1_TIMER_SEL_O <= l1_timer_q;
		end
	end
endmodule : bcpm_regs

//--- sim/bcpm_regs_checker.sv
// Port assertions for the clock power and capability register bank.
// Assumes one clock, a synchronous active low reset, reads one cycle late.
`timescale 1ns/1ps
module bcpm_regs_checker #(
	parameter logic [15:0] SUBSYS_VENDOR_ID = 16'h1A2B
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [7:0] ADDR_I,
	input wire logic RD_I,
	input wire logic [31:0] RDATA_O,
	input wire logic D3HOT_I,
	input wire logic SEC_BUS_IDLE_I,
	input wire logic PRI_REQ_PEND_I,
	input wire logic L0S_REQ_I,
	input wire logic LEGACY_MODE_I,
	input wire logic CLK_PM_EN_O,
	input wire logic CLKRUN_EN_O,
	input wire logic SEC_CLK_STOP_O,
	input wire logic L0S_ENTER_O
);
	logic rp;
	logic [7:0] ra;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	always_ff @(posedge CLK_I) begin
		rp <= RD_I;
		ra <= ADDR_I;
	end
	unmapped_read_a: assert property (rp && !(ra inside {8'h9C, 8'hA4,
		8'hA8, 8'hAC}) |-> RDATA_O == 32'h0) else $error("unmapped read");
	cap_header_a: assert property (rp && ra == 8'hA8 |->
		RDATA_O[31:16] == 16'h0 && RDATA_O[7:0] == 8'h0D) else $error("hdr");
	legacy_ptr_a: assert property (rp && ra == 8'hA8 &&
		$past(LEGACY_MODE_I) |-> RDATA_O[15:8] == 8'hF0) else $error("ptr");
	vendor_id_a: assert property (rp && ra == 8'hAC |->
		RDATA_O == {16'h0, SUBSYS_VENDOR_ID}) else $error("vendor id");
	tuning_rsvd_a: assert property (rp && ra == 8'hA4 |->
		RDATA_O[31:21] == 11'h0 && RDATA_O[15:0] == 16'h0) else $error("a4");
	clkrun_off_a: assert property (!CLK_PM_EN_O |->
		!CLKRUN_EN_O && !SEC_CLK_STOP_O) else $error("clkrun on");
	clkrun_dflt_a: assert property ($rose(CLK_PM_EN_O) |->
		CLKRUN_EN_O) else $error("clkrun default");
	stop_cause_a: assert property (SEC_CLK_STOP_O |-> $past(D3HOT_I, 2) ||
		$past(SEC_BUS_IDLE_I && !PRI_REQ_PEND_I, 2)) else $error("stop");
	l0s_cause_a: assert property (L0S_ENTER_O |->
		$past(L0S_REQ_I, 2)) else $error("l0s");
	cover property (rp && ra == 8'hA8 && LEGACY_MODE_I);
	cover property ($rose(SEC_CLK_STOP_O));
	cover property ($rose(L0S_ENTER_O));
endmodule : bcpm_regs_checker
bind bcpm_regs bcpm_regs_checker #(.SUBSYS_VENDOR_ID(SUBSYS_VENDOR_ID)) i_chk (
	.CLK_I, .RST_N_I, .ADDR_I, .RD_I, .RDATA_O, .D3HOT_I, .SEC_BUS_IDLE_I,
	.PRI_REQ_PEND_I, .L0S_REQ_I, .LEGACY_MODE_I, .CLK_PM_EN_O, .CLKRUN_EN_O,
	.SEC_CLK_STOP_O, .L0S_ENTER_O);

//--- sim/bcpm_host.sv
// Host model issuing register accesses, plus the board strap levels.
// Assumes strobes are taken at the rising edge and reads answer one later.
`timescale 1ns/1ps
module bcpm_host (
	input wire logic clk_i,
	input wire logic [31:0] rdata_i,
	output logic [7:0] addr_o = 8'h0,
	output logic [31:0] wdata_o = 32'h0,
	output logic wr_o = 1'b0,
	output logic rd_o = 1'b0,
	output logic [1:0] strap_n_o = 2'h3
);
	task strap(input logic [1:0] v);
		@(posedge clk_i) strap_n_o <= v;
	endtask : strap
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1 d = rdata_i;
	endtask : rd
endmodule : bcpm_host

//--- sim/test_bcpm_regs.sv
// Self-checking bench for the clock power and capability register bank.
// Assumes the host model drives the register port and the straps.
`timescale 1ns/1ps
module test_bcpm_regs;
	logic CLK_I = 1'b0;
	logic RST_N_I = 1'b0;
	logic [7:0] ADDR_I;
	logic [31:0] WDATA_I, RDATA_O;
	logic WR_I, RD_I, CLK_PM_EN_O, CLKRUN_EN_O, SEC_CLK_STOP_O, L0S_ENTER_O;
	logic [1:0] STRAP_REQ_N_I, SCRAMBLE_CTRL_O, L1_TIMER_SEL_O;
	logic D3HOT_I = 0, SEC_BUS_IDLE_I = 0, PRI_REQ_PEND_I = 0;
	logic RX_ELEC_IDLE_I = 0, L0S_REQ_I = 0;
	logic SLOT_ID_CAP_EN_I = 0, LEGACY_MODE_I = 0;
	int failures = 0;
	int compares = 0;
	always #4 CLK_I = ~CLK_I;
	bcpm_host i_host (.clk_i(CLK_I), .rdata_i(RDATA_O), .addr_o(ADDR_I),
		.wdata_o(WDATA_I), .wr_o(WR_I), .rd_o(RD_I), .strap_n_o(STRAP_REQ_N_I));
	bcpm_regs i_dut (.CLK_I, .RST_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
		.RDATA_O, .STRAP_REQ_N_I, .D3HOT_I, .SEC_BUS_IDLE_I, .PRI_REQ_PEND_I,
		.RX_ELEC_IDLE_I, .L0S_REQ_I, .SLOT_ID_CAP_EN_I, .LEGACY_MODE_I,
		.CLK_PM_EN_O, .CLKRUN_EN_O, .SEC_CLK_STOP_O, .L0S_ENTER_O,
		.SCRAMBLE_CTRL_O, .L1_TIMER_SEL_O);
	task print_verdict();
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		i_host.rd(a, d);
		chk("rdata", e, d);
	endtask : rc
	task w3();
		repeat (3) @(posedge CLK_I);
		#1;
	endtask : w3
	task rst(input logic [1:0] s);
		i_host.strap(s);
		@(posedge CLK_I) RST_N_I <= 1'b0;
		repeat (4) @(posedge CLK_I);
		RST_N_I <= 1'b1;
		w3();
	endtask : rst
	initial begin
		#100000;
		failures++;
		print_verdict();
	end
	initial begin
		rst(2'b11);
		chk("pm_en", 32'h0, 32'(CLK_PM_EN_O));
		chk("clkrun", 32'h0, 32'(CLKRUN_EN_O));
		i_host.wr(8'h9C, 32'h3);
		rc(8'h9C, 32'h0);
		rc(8'hA4, 32'h0009_0000);
		rc(8'hA8, 32'h0000_B00D);
		rc(8'hAC, 32'h0000_1A2B);
		rc(8'h10, 32'h0);
		rst(2'b00);
		chk("pm_en", 32'h1, 32'(CLK_PM_EN_O));
		chk("clkrun", 32'h1, 32'(CLKRUN_EN_O));
		rc(8'h9C, 32'h1);
		i_host.wr(8'hA4, 32'hFFFF_FFFF);
		rc(8'hA4, 32'h001F_0000);
		chk("scramble", 32'h3, 32'(SCRAMBLE_CTRL_O));
		chk("l1_timer", 32'h3, 32'(L1_TIMER_SEL_O));
		@(posedge CLK_I) L0S_REQ_I <= 1'b1;
		w3();
		chk("l0s", 32'h0, 32'(L0S_ENTER_O));
		@(posedge CLK_I) RX_ELEC_IDLE_I <= 1'b1;
		w3();
		chk("l0s", 32'h1, 32'(L0S_ENTER_O));
		i_host.wr(8'hA4, 32'h0);
		RX_ELEC_IDLE_I <= 1'b0;
		w3();
		chk("l0s", 32'h1, 32'(L0S_ENTER_O));
		@(posedge CLK_I) D3HOT_I <= 1'b1;
		w3();
		chk("stop", 32'h1, 32'(SEC_CLK_STOP_O));
		@(posedge CLK_I) D3HOT_I <= 1'b0;
		SEC_BUS_IDLE_I <= 1'b1;
		w3();
		chk("stop", 32'h0, 32'(SEC_CLK_STOP_O));
		i_host.wr(8'h9C, 32'h3);
		w3();
		chk("stop", 32'h1, 32'(SEC_CLK_STOP_O));
		rc(8'h9C, 32'h7);
		@(posedge CLK_I) PRI_REQ_PEND_I <= 1'b1;
		w3();
		chk("stop", 32'h0, 32'(SEC_CLK_STOP_O));
		i_host.wr(8'hA8, 32'h0000_A000);
		rc(8'hA8, 32'h0000_B00D);
		@(posedge CLK_I) SLOT_ID_CAP_EN_I <= 1'b1;
		i_host.wr(8'hA8, 32'h0000_A000);
		rc(8'hA8, 32'h0000_A00D);
		@(posedge CLK_I) LEGACY_MODE_I <= 1'b1;
		rc(8'hA8, 32'h0000_F00D);
		print_verdict();
	end
endmodule : test_bcpm_regs
